// >>> verilog/esd_top.sv
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "esd_defs.svh"
module esd_top
  import esd_pkg::*;
#(
  parameter int          NUM_EVT   = 4,
  parameter int unsigned FLASH_CYC = `ESD_FLASH_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic signed [19:0]  measured_value_i,
  input  wire logic                ctrl_out_i,
  input  wire logic [NUM_EVT-1:0]  evt_i,
  input  wire logic [6:0]          fault_i,
  input  wire logic                supply_fail_i,
  input  wire logic                ram_fail_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     ctrl_out_o,
  output logic [NUM_EVT-1:0]       evt_o,
  output logic                     disp_on_o,
  output logic                     pv_visible_o,
  output logic                     over_o,
  output logic                     under_o,
  output logic                     in_err_o,
  output logic                     err_ind_o,
  output logic [11:0]              err_code_o,
  output logic                     irq_o
);

  localparam int FCW = $clog2(FLASH_CYC + 1);

  // Registers
  logic [31:0]        ctrl_ff, nxt_ctrl;
  logic signed [19:0] sc_hi_ff, nxt_sc_hi, sc_lo_ff, nxt_sc_lo;
  logic signed [19:0] ep_hi_ff, nxt_ep_hi, ep_lo_ff, nxt_ep_lo;
  logic [2:0]         ist_ff, nxt_ist, imsk_ff, nxt_imsk;
  logic [11:0]        code_ff, nxt_code;
  logic [1:0]         halt_sy1_ff, halt_sy2_ff, halt_sy3_ff;
  logic [6:0]         f_sy1_ff, f_sy2_ff, f_sy3_ff;
  esd_mode_e          mode_ff, nxt_mode;
  logic [FCW-1:0]     fcnt_ff, nxt_fcnt;
  logic               blink_ff, nxt_blink;
  logic [31:0]        rdat_ff, nxt_rdat;
  logic               ack_ff, nxt_ack;
  logic               ctrl_out_ff, nxt_ctrl_out;
  logic [NUM_EVT-1:0] evt_ff, nxt_evt;
  logic               disp_ff, nxt_disp, pvv_ff, nxt_pvv, ov_ff, nxt_ov, un_ff, nxt_un;
  logic               ie_ff, nxt_ie, eind_ff, nxt_eind, irq_ff, nxt_irq;
  logic [11:0]        codeo_ff, nxt_codeo;

  logic over_c, under_c, ierr_c, halt_c, wr_c, rd_c;
  logic [11:0] fault_bits_c;

  // Fault input synchronisers; only stages two and three are compared
  always_ff @(posedge clk_i) begin
    f_sy1_ff    <= fault_i;
    f_sy2_ff    <= f_sy1_ff;
    f_sy3_ff    <= f_sy2_ff;
    halt_sy1_ff <= {supply_fail_i, ram_fail_i};
    halt_sy2_ff <= halt_sy1_ff;
    halt_sy3_ff <= halt_sy2_ff;
  end

  // Input classification
  always_comb begin
    over_c  = measured_value_i > `ESD_DISP_MAX;
    under_c = measured_value_i < `ESD_DISP_MIN;
    ierr_c  = over_c || under_c || (measured_value_i > sc_hi_ff)
           || (measured_value_i < sc_lo_ff) || (measured_value_i > ep_hi_ff)
           || (measured_value_i < ep_lo_ff);
    halt_c  = (halt_sy2_ff[1] & halt_sy3_ff[1]) | (halt_sy2_ff[0] & halt_sy3_ff[0]);
    // Each fault maps to its own power-of-two code
    fault_bits_c = 12'h000;
    if (f_sy2_ff[0] & f_sy3_ff[0]) fault_bits_c = fault_bits_c | `ESD_F_ADJ;
    if (f_sy2_ff[1] & f_sy3_ff[1]) fault_bits_c = fault_bits_c | `ESD_F_BACKUP;
    if (f_sy2_ff[2] & f_sy3_ff[2]) fault_bits_c = fault_bits_c | `ESD_F_ADC;
    if (f_sy2_ff[3] & f_sy3_ff[3]) fault_bits_c = fault_bits_c | `ESD_F_CUSTOM;
    if (f_sy2_ff[4] & f_sy3_ff[4]) fault_bits_c = fault_bits_c | `ESD_F_WDT;
    if (f_sy2_ff[5] & f_sy3_ff[5]) fault_bits_c = fault_bits_c | `ESD_F_STACK;
    if (f_sy2_ff[6] & f_sy3_ff[6]) fault_bits_c = fault_bits_c | `ESD_F_BUSY;
  end

  // Bus strobes; halted device gives no answer at all
  assign wr_c = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff & (mode_ff != ESD_HALT);
  assign rd_c = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff & (mode_ff != ESD_HALT);

  // Register file, latched faults, mode and flash timer
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_sc_hi = sc_hi_ff;
    nxt_sc_lo = sc_lo_ff;
    nxt_ep_hi = ep_hi_ff;
    nxt_ep_lo = ep_lo_ff;
    nxt_imsk  = imsk_ff;
    nxt_ist   = ist_ff;
    nxt_ack   = wr_c | rd_c;
    nxt_rdat  = 32'h0000_0000;
    // Distinct bits, so OR equals the sum; held until reset
    nxt_code  = code_ff | fault_bits_c;
    if (wr_c) begin
      case (wb_adr_i)
        `ESD_R_CTRL:     nxt_ctrl  = wb_dat_i;
        `ESD_R_SCALE_HI: nxt_sc_hi = wb_dat_i[19:0];
        `ESD_R_SCALE_LO: nxt_sc_lo = wb_dat_i[19:0];
        `ESD_R_ERRPT_HI: nxt_ep_hi = wb_dat_i[19:0];
        `ESD_R_ERRPT_LO: nxt_ep_lo = wb_dat_i[19:0];
        `ESD_R_IRQ_STAT: nxt_ist   = ist_ff & ~wb_dat_i[2:0];
        `ESD_R_IRQ_MASK: nxt_imsk  = wb_dat_i[2:0];
        default: ;
      endcase
    end
    if (rd_c) begin
      case (wb_adr_i)
        `ESD_R_CTRL:     nxt_rdat = ctrl_ff;
        `ESD_R_SCALE_HI: nxt_rdat = {{12{sc_hi_ff[19]}}, sc_hi_ff};
        `ESD_R_SCALE_LO: nxt_rdat = {{12{sc_lo_ff[19]}}, sc_lo_ff};
        `ESD_R_ERRPT_HI: nxt_rdat = {{12{ep_hi_ff[19]}}, ep_hi_ff};
        `ESD_R_ERRPT_LO: nxt_rdat = {{12{ep_lo_ff[19]}}, ep_lo_ff};
        `ESD_R_STATUS:   nxt_rdat = {27'h000_0000, mode_ff, ierr_c, under_c, over_c};
        `ESD_R_IRQ_STAT: nxt_rdat = {29'h0000_0000, ist_ff};
        `ESD_R_IRQ_MASK: nxt_rdat = {29'h0000_0000, imsk_ff};
        `ESD_R_ERRCODE:  nxt_rdat = {20'h0_0000, code_ff};
        default:         nxt_rdat = 32'h0000_0000;
      endcase
    end
    // Sticky events; a new event beats a clear in the same cycle
    nxt_ist = nxt_ist | {halt_c, |fault_bits_c, ierr_c};
    // Halt outranks diagnostics; no way back short of reset
    case (mode_ff)
      ESD_RUN:  nxt_mode = halt_c ? ESD_HALT : (|nxt_code ? ESD_DIAG : ESD_RUN);
      ESD_DIAG: nxt_mode = halt_c ? ESD_HALT : ESD_DIAG;
      ESD_HALT: nxt_mode = ESD_HALT;
      default:  nxt_mode = ESD_HALT;
    endcase
    if (fcnt_ff >= FCW'(FLASH_CYC - 1)) begin
      nxt_fcnt  = '0;
      nxt_blink = ~blink_ff;
    end else begin
      nxt_fcnt  = fcnt_ff + 1'b1;
      nxt_blink = blink_ff;
    end
  end

  // Output shaping per mode
  always_comb begin
    nxt_disp     = 1'b1;
    nxt_ov       = over_c;
    nxt_un       = under_c;
    nxt_ie       = ierr_c;
    nxt_eind     = 1'b0;
    nxt_codeo    = 12'h000;
    nxt_irq      = |(ist_ff & imsk_ff);
    // Steady display is allowed when flashing is switched off
    nxt_pvv      = ~ierr_c | ~ctrl_ff[`ESD_C_FLASH_EN] | blink_ff;
    nxt_ctrl_out = ctrl_out_i;
    nxt_evt      = evt_i;
    if (ierr_c) begin
      // Over side uses the high-limit action, else the low one
      nxt_ctrl_out = (over_c || measured_value_i > sc_hi_ff || measured_value_i > ep_hi_ff)
                   ? ctrl_ff[`ESD_C_OUT_HI] : ctrl_ff[`ESD_C_OUT_LO];
      nxt_evt      = ctrl_ff[`ESD_C_EVT_LSB +: NUM_EVT];
    end
    case (mode_ff)
      ESD_DIAG: begin
        nxt_ctrl_out = 1'b0;
        nxt_evt      = '0;
        nxt_eind     = 1'b1;
        nxt_codeo    = code_ff;
        nxt_pvv      = 1'b0;
      end
      ESD_HALT: begin
        nxt_disp     = 1'b0;
        nxt_pvv      = 1'b0;
        nxt_ov       = 1'b0;
        nxt_un       = 1'b0;
        nxt_ie       = 1'b0;
        nxt_ctrl_out = 1'b0;
        nxt_evt      = '0;
      end
      default: ;
    endcase
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_ff     <= `ESD_CTRL_RST;
      sc_hi_ff    <= `ESD_DISP_MAX;
      sc_lo_ff    <= `ESD_DISP_MIN;
      ep_hi_ff    <= `ESD_DISP_MAX;
      ep_lo_ff    <= `ESD_DISP_MIN;
      ist_ff      <= 3'h0;
      imsk_ff     <= 3'h0;
      code_ff     <= 12'h000;
      mode_ff     <= ESD_RUN;
      fcnt_ff     <= '0;
      blink_ff    <= 1'b0;
      rdat_ff     <= 32'h0000_0000;
      ack_ff      <= 1'b0;
      ctrl_out_ff <= 1'b0;
      evt_ff      <= '0;
      disp_ff     <= 1'b0;
      pvv_ff      <= 1'b0;
      ov_ff       <= 1'b0;
      un_ff       <= 1'b0;
      ie_ff       <= 1'b0;
      eind_ff     <= 1'b0;
      codeo_ff    <= 12'h000;
      irq_ff      <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      sc_hi_ff    <= nxt_sc_hi;
      sc_lo_ff    <= nxt_sc_lo;
      ep_hi_ff    <= nxt_ep_hi;
      ep_lo_ff    <= nxt_ep_lo;
      ist_ff      <= nxt_ist;
      imsk_ff     <= nxt_imsk;
      code_ff     <= nxt_code;
      mode_ff     <= nxt_mode;
      fcnt_ff     <= nxt_fcnt;
      blink_ff    <= nxt_blink;
      rdat_ff     <= nxt_rdat;
      ack_ff      <= nxt_ack;
      ctrl_out_ff <= nxt_ctrl_out;
      evt_ff      <= nxt_evt;
      disp_ff     <= nxt_disp;
      pvv_ff      <= nxt_pvv;
      ov_ff       <= nxt_ov;
      un_ff       <= nxt_un;
      ie_ff       <= nxt_ie;
      eind_ff     <= nxt_eind;
      codeo_ff    <= nxt_codeo;
      irq_ff      <= nxt_irq;
    end
  end

  assign wb_dat_o     = rdat_ff;
  assign wb_ack_o     = ack_ff;
  assign ctrl_out_o   = ctrl_out_ff;
  assign evt_o        = evt_ff;
  assign disp_on_o    = disp_ff;
  assign pv_visible_o = pvv_ff;
  assign over_o       = ov_ff;
  assign under_o      = un_ff;
  assign in_err_o     = ie_ff;
  assign err_ind_o    = eind_ff;
  assign err_code_o   = codeo_ff;
  assign irq_o        = irq_ff;

  // Checks
  property p_over;
    @(posedge clk_i) disable iff (srst_i)
      (mode_ff == ESD_RUN && measured_value_i > `ESD_DISP_MAX) |=> over_o && in_err_o;
  endproperty
  a_over: assert property (p_over) else $error("over-scale not flagged");

  property p_under;
    @(posedge clk_i) disable iff (srst_i)
      (mode_ff == ESD_RUN && measured_value_i < `ESD_DISP_MIN) |=> under_o && in_err_o;
  endproperty
  a_under: assert property (p_under) else $error("underscale not flagged");

  property p_ierr;
    @(posedge clk_i) disable iff (srst_i)
      (mode_ff == ESD_RUN && measured_value_i > ep_hi_ff) |=> in_err_o;
  endproperty
  a_ierr: assert property (p_ierr) else $error("input error missed");

  property p_steady;
    @(posedge clk_i) disable iff (srst_i)
      (mode_ff == ESD_RUN && !ctrl_ff[`ESD_C_FLASH_EN]) |=> pv_visible_o;
  endproperty
  a_steady: assert property (p_steady) else $error("steady display flashed");

  property p_evt;
    @(posedge clk_i) disable iff (srst_i)
      (mode_ff == ESD_RUN && ierr_c) |=> evt_o == $past(ctrl_ff[`ESD_C_EVT_LSB +: NUM_EVT]);
  endproperty
  a_evt: assert property (p_evt) else $error("event action wrong");

  property p_diag;
    @(posedge clk_i) disable iff (srst_i)
      (mode_ff == ESD_DIAG) |=> err_ind_o && !ctrl_out_o && evt_o == '0 && err_code_o != 0;
  endproperty
  a_diag: assert property (p_diag) else $error("fault display or outputs wrong");

  property p_latch;
    @(posedge clk_i) disable iff (srst_i)
      code_ff != 12'h000 |=> (code_ff & $past(code_ff)) == $past(code_ff);
  endproperty
  a_latch: assert property (p_latch) else $error("fault code lost");

  property p_halt;
    @(posedge clk_i) disable iff (srst_i)
      (mode_ff == ESD_HALT) |=> !disp_on_o && !wb_ack_o && err_code_o == 12'h000;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not silent");

endmodule

// >>> verilog/esd_defs.svh
`ifndef ESD_DEFS_SVH
`define ESD_DEFS_SVH
// Display range caps
`define ESD_DISP_MAX        20'sh0_4E1F
`define ESD_DISP_MIN        (-20'sh0_4E1F)
// Fault code bit values
`define ESD_F_ADJ           12'h001
`define ESD_F_BACKUP        12'h002
`define ESD_F_ADC           12'h004
`define ESD_F_CUSTOM        12'h020
`define ESD_F_WDT           12'h080
`define ESD_F_STACK         12'h100
`define ESD_F_BUSY          12'h800
// Register offsets
`define ESD_R_CTRL          8'h00
`define ESD_R_SCALE_HI      8'h04
`define ESD_R_SCALE_LO      8'h08
`define ESD_R_ERRPT_HI      8'h0C
`define ESD_R_ERRPT_LO      8'h10
`define ESD_R_STATUS        8'h14
`define ESD_R_IRQ_STAT      8'h18
`define ESD_R_IRQ_MASK      8'h1C
`define ESD_R_ERRCODE       8'h20
// Control reset value: flashing on, all actions off
`define ESD_CTRL_RST        32'h0000_0001
// Control field positions
`define ESD_C_FLASH_EN      0
`define ESD_C_OUT_HI        1
`define ESD_C_OUT_LO        2
`define ESD_C_EVT_LSB       3
// Flash timing: 0.5 s half period at 20 MHz
`define ESD_FLASH_MS        500
`define ESD_CLK_KHZ         20000
`define ESD_FLASH_CYC       (`ESD_FLASH_MS * `ESD_CLK_KHZ)
`endif

// >>> verilog/esd_pkg.sv
package esd_pkg;
  typedef enum logic [1:0] {
    ESD_RUN   = 2'b00,
    ESD_DIAG  = 2'b01,
    ESD_HALT  = 2'b11
  } esd_mode_e;
endpackage

// >>> tb/test_error_status_display_logic.sv
`timescale 1ns/10ps
`include "esd_defs.svh"
// One compare: counts every check, reports a mismatch at once
`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module test_error_status_display_logic;
  import esd_pkg::*;
  logic               clk_i = 1'b0;
  logic               srst_i = 1'b1;
  logic signed [19:0] mv = 20'sh0_0000;
  logic               ctrl_i = 1'b0;
  logic [3:0]         evt_i = 4'h0;
  logic [6:0]         fault_i = 7'h00;
  logic               sup_i = 1'b0;
  logic               ram_i = 1'b0;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        dat = 32'h0000_0000;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        dat_o;
  logic               ack, ctrl_o, disp_on, pv_vis, over, under, in_err, err_ind, irq;
  logic [3:0]         evt_o;
  logic [11:0]        code;
  logic [31:0]        seed = 32'hd108;
  logic [31:0]        rd;
  logic               ok;
  int                 num_errors = 0;
  int                 checked = 0;
  esd_top #(.NUM_EVT(4), .FLASH_CYC(4)) dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .measured_value_i(mv), .ctrl_out_i(ctrl_i),
    .evt_i(evt_i), .fault_i(fault_i), .supply_fail_i(sup_i), .ram_fail_i(ram_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .ctrl_out_o(ctrl_o),
    .evt_o(evt_o), .disp_on_o(disp_on), .pv_visible_o(pv_vis), .over_o(over),
    .under_o(under), .in_err_o(in_err), .err_ind_o(err_ind), .err_code_o(code),
    .irq_o(irq));
  // 50 ns period
  always #25 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Combined code from the per-fault weights
  function automatic logic [11:0] exp_code(input logic [6:0] f);
    logic [11:0] w [7];
    logic [11:0] sum;
    w = '{12'h001, 12'h002, 12'h004, 12'h020, 12'h080, 12'h100, 12'h800};
    sum = 12'h000;
    for (int i = 0; i < 7; i++) if (f[i]) sum = sum + w[i];
    return sum;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic single cycle; a missing ack ends the run unless no answer is expected
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic want);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) begin
        ok = 1'b1;
        rd = dat_o;
      end
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
    @(posedge clk_i);
    if (want && !ok) begin
      num_errors++;
      $display("[ERR] ack expected 1 seen 0");
      tally_and_finish();
    end
  endtask
  task automatic do_reset;
    @(posedge clk_i);
    srst_i  <= 1'b1;
    fault_i <= 7'h00;
    sup_i   <= 1'b0;
    ram_i   <= 1'b0;
    // Two edges with reset seen by the design
    cyc_wait(1);
    @(negedge clk_i);
    `CHK("outs_in_reset", 5'h00, {ack, irq, err_ind, in_err, disp_on})
    @(posedge clk_i);
    srst_i <= 1'b0;
    cyc_wait(1);
  endtask
  initial begin : main
    logic [6:0] cfg;
    logic       ie, hi;
    int         v, nhi, nlo;
    int         corner [6];
    corner = '{19999, 20000, -19999, -20000, 8000, -10001};
    do_reset();
    // Reset values and unmapped place
    wb(1'b0, `ESD_R_CTRL, 32'h0, 1'b1);
    `CHK("ctrl_flash_rst", 1'b1, rd[0])
    wb(1'b0, `ESD_R_ERRPT_HI, 32'h0, 1'b1);
    `CHK("errpt_hi_rst", 20'h0_4E1F, rd[19:0])
    wb(1'b1, 8'h40, 32'hFFFF_FFFF, 1'b1);
    wb(1'b0, 8'h40, 32'h0, 1'b1);
    `CHK("unmapped", 32'h0000_0000, rd)
    wb(1'b1, `ESD_R_SCALE_HI, 32'(12000), 1'b1);
    wb(1'b1, `ESD_R_SCALE_LO, 32'(-10000), 1'b1);
    wb(1'b1, `ESD_R_ERRPT_HI, 32'(8000), 1'b1);
    wb(1'b1, `ESD_R_ERRPT_LO, 32'(-15000), 1'b1);
    wb(1'b1, `ESD_R_IRQ_MASK, 32'h0, 1'b1);
    // Limits read back sign extended
    wb(1'b0, `ESD_R_SCALE_HI, 32'h0, 1'b1);
    `CHK("scale_hi_rb", 32'(12000), rd)
    wb(1'b0, `ESD_R_ERRPT_LO, 32'h0, 1'b1);
    `CHK("errpt_lo_rb", 32'(-15000), rd)
    // Corner values first, then random ones; steady display selected
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      v = (k < 6) ? corner[k] : int'(seed % 50001) - 25000;
      cfg = {seed[9:4], 1'b0};
      wb(1'b1, `ESD_R_CTRL, {25'h0, cfg}, 1'b1);
      mv     <= 20'(v);
      ctrl_i <= seed[12];
      evt_i  <= seed[16:13];
      cyc_wait(3);
      @(negedge clk_i);
      hi = v > 8000;
      ie = hi || v < -10000;
      `CHK("over", v > 19999, over)
      `CHK("under", v < -19999, under)
      `CHK("in_err", ie, in_err)
      `CHK("pv_steady", 1'b1, pv_vis)
      `CHK("disp_on", 1'b1, disp_on)
      `CHK("ctrl_o", ie ? (hi ? cfg[1] : cfg[2]) : ctrl_i, ctrl_o)
      `CHK("evt_o", ie ? cfg[6:3] : evt_i, evt_o)
    end
    $display("test range_and_actions done");
    // Flashing versus steady during an input error
    for (int f = 1; f >= 0; f--) begin
      wb(1'b1, `ESD_R_CTRL, 32'(f), 1'b1);
      @(posedge clk_i);
      mv <= 20'(30000);
      nhi = 0;
      nlo = 0;
      cyc_wait(3);
      for (int i = 0; i < 20; i++) begin
        @(negedge clk_i);
        if (pv_vis === 1'b1) nhi++;
        if (pv_vis === 1'b0) nlo++;
      end
      `CHK("pv_blink", f ? 1'b1 : 1'b0, nhi > 0 && nlo > 0)
    end
    wb(1'b0, `ESD_R_STATUS, 32'h0, 1'b1);
    `CHK("status", 5'b00101, rd[4:0])
    $display("test flash done");
    // Interrupt: sticky, masked, cleared by writing one
    @(negedge clk_i);
    `CHK("irq_masked", 1'b0, irq)
    wb(1'b1, `ESD_R_IRQ_MASK, 32'h7, 1'b1);
    cyc_wait(2);
    @(negedge clk_i);
    `CHK("irq_on", 1'b1, irq)
    @(posedge clk_i);
    mv <= 20'(0);
    cyc_wait(3);
    @(negedge clk_i);
    `CHK("irq_sticky", 1'b1, irq)
    wb(1'b1, `ESD_R_IRQ_STAT, 32'h1, 1'b1);
    wb(1'b0, `ESD_R_IRQ_STAT, 32'h0, 1'b1);
    `CHK("irq_stat_clr", 1'b0, rd[0])
    @(negedge clk_i);
    `CHK("irq_off", 1'b0, irq)
    $display("test irq done");
    // Self-diagnostic faults, each set fresh after reset
    for (int k = 0; k < 4; k++) begin
      do_reset();
      seed = lfsr(seed);
      cfg = (k == 0) ? 7'h7F : (seed[6:0] | 7'h01);
      @(posedge clk_i);
      fault_i <= cfg;
      ctrl_i  <= 1'b1;
      evt_i   <= 4'hF;
      mv      <= 20'(30000);
      cyc_wait(10);
      @(posedge clk_i);
      fault_i <= 7'h00;
      cyc_wait(5);
      @(negedge clk_i);
      `CHK("err_ind", 1'b1, err_ind)
      `CHK("err_code", exp_code(cfg), code)
      `CHK("outs_off", 5'h00, {ctrl_o, evt_o})
      wb(1'b0, `ESD_R_ERRCODE, 32'h0, 1'b1);
      `CHK("errcode_reg", exp_code(cfg), rd[11:0])
    end
    $display("test faults done");
    // Supply and RAM faults halt all outputs except irq_o, even with a fault pending
    for (int k = 0; k < 2; k++) begin
      do_reset();
      @(posedge clk_i);
      sup_i   <= (k == 0);
      ram_i   <= (k == 1);
      fault_i <= 7'h05;
      cyc_wait(10);
      @(negedge clk_i);
      `CHK("halt_no_code", 13'h0000, {err_ind, code})
      `CHK("halt_blank", 6'h00, {disp_on, ctrl_o, evt_o})
      wb(1'b0, `ESD_R_STATUS, 32'h0, 1'b0);
      `CHK("halt_no_ack", 1'b0, ok)
    end
    $display("test halt done");
    tally_and_finish();
  end
endmodule
